// *** rtl/flash_protect_pkg.sv ***
// constants and types for the flash write-protection block
package flash_protect_pkg;
   localparam int ADDR_W = 19;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] ARRAY_ERASED = 8'hff;
   localparam int CLK_MHZ = 50;
   // times in their own units, as printed
   localparam int SUSPEND_LAT_US = 30;
   localparam int PROG_MAX_MS = 3;
   localparam int ERASE_MAX_MS = 20;
   localparam int WRSR_MAX_MS = 12;
   localparam int DP_ENTRY_US = 3;
   localparam int DP_RELEASE_US = 8;
   // cycle counts, each time multiplied by CLK_MHZ, with no rounding
   localparam int SUSPEND_CYC = SUSPEND_LAT_US * CLK_MHZ;
   localparam int PROG_CYC = PROG_MAX_MS * 1000 * CLK_MHZ;
   localparam int ERASE_CYC = ERASE_MAX_MS * 1000 * CLK_MHZ;
   localparam int WRSR_CYC = WRSR_MAX_MS * 1000 * CLK_MHZ;
   localparam int DP_ENTRY_CYC = DP_ENTRY_US * CLK_MHZ;
   localparam int DP_RELEASE_CYC = DP_RELEASE_US * CLK_MHZ;
   localparam int CNT_W = 24;
   localparam int BLOCK64_SHIFT = 16;
   localparam int SECTOR4_SHIFT = 12;

   typedef enum logic [2:0] {
      CMD_NONE, CMD_SET_WRITE_ENABLE_COMMAND, CMD_WRDI, CMD_WRSR, CMD_PROGRAM, CMD_ERASE,
      CMD_DEEP_DOWN, CMD_RELEASE
   } cmd_e;

   typedef struct packed {
      logic protect_complement_bit;
      logic status_protect_bit_b;
      logic status_protect_bit_a;
      logic protect_granularity_bit;
      logic protect_bottom_select_bit;
      logic [2:0] protect_size;
   } protect_cfg_s;

   typedef struct packed {
      cmd_e code;
      logic [ADDR_W-1:0] addr;
      logic [7:0] status_data;
      protect_cfg_s cfg_data;
   } cmd_s;
endpackage : flash_protect_pkg

// *** rtl/flash_protect.sv ***
// write-protection and operation timing of a serial flash
`timescale 1ns/10ps
`default_nettype none
module flash_protect
   import flash_protect_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYC,
   parameter int ERASE_CYCLES = ERASE_CYC,
   parameter int WRSR_CYCLES = WRSR_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // decoded command from the serial front end
   input wire logic cmd_valid,
   input wire flash_protect_pkg::cmd_s cmd,
   input wire logic cmd_byte_aligned,
   input wire logic suspend_req,
   input wire logic resume_req,
   // pins
   input wire logic write_protect_n,
   // status
   output logic busy,
   output logic write_enable_latch,
   output logic suspended,
   output logic deep_down,
   output flash_protect_pkg::protect_cfg_s protect_cfg,
   output logic [7:0] status_byte,
   // array write strobes, their address and the reject flag
   output logic array_program,
   output logic array_erase,
   output logic [ADDR_W-1:0] array_addr,
   output logic cmd_rejected
);
   import flash_protect_pkg::*;

   typedef enum logic [2:0] {
      ST_STANDBY, ST_PROGRAM, ST_ERASE, ST_WRSR, ST_SUSPENDING,
      ST_SUSPENDED, ST_DP_ENTER, ST_DP_EXIT
   } state_e;

   logic rst_meta_reg;
   logic rst_sync_reg;
   state_e state_reg;
   state_e resume_state_reg;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] saved_count_reg;
   logic in_dp_reg;
   logic protected_hit;
   logic accept;
   logic is_write_cmd;

   // reset release through two flops
   // every later flop leaves reset on the same edge
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // protected region decode on the target address
   function automatic logic in_region(input protect_cfg_s c,
                                      input logic [ADDR_W-1:0] a);
      logic hit;
      logic [2:0] blk;
      logic [2:0] sec;
      hit = 1'b0;
      blk = a[ADDR_W-1:BLOCK64_SHIFT];
      sec = a[BLOCK64_SHIFT-2:SECTOR4_SHIFT];
      if (c.protect_size == 3'h0) begin
         hit = 1'b0;
      end else if (!c.protect_granularity_bit) begin
         if (c.protect_size[2]) begin
            hit = 1'b1;
         end else begin
            case (c.protect_size[1:0])
               2'h1: hit = c.protect_bottom_select_bit ? (blk == 3'h0)
                           : (blk == 3'h7);
               2'h2: hit = c.protect_bottom_select_bit ? (blk[2:1] == 2'h0)
                           : (blk[2:1] == 2'h3);
               default: hit = c.protect_bottom_select_bit ? !blk[2]
                           : blk[2];
            endcase
         end
      end else if (c.protect_size == 3'h7) begin
         hit = 1'b1;
      end else begin
         // sector mode applies inside the end block only
         // the end block's outer half holds the sector-mode region
         if (c.protect_bottom_select_bit) begin
            hit = (blk == 3'h0) && !a[BLOCK64_SHIFT-1];
            case (c.protect_size)
               3'h1: hit = hit && (sec == 3'h0);
               3'h2: hit = hit && (sec[2:1] == 2'h0);
               3'h3: hit = hit && !sec[2];
               default: hit = hit;
            endcase
         end else begin
            hit = (blk == 3'h7) && a[BLOCK64_SHIFT-1];
            case (c.protect_size)
               3'h1: hit = hit && (sec == 3'h7);
               3'h2: hit = hit && (sec[2:1] == 2'h3);
               3'h3: hit = hit && sec[2];
               default: hit = hit;
            endcase
         end
      end
      // complement inverts every row, the all/none rows swap too
      if (c.protect_complement_bit) begin
         hit = !hit;
      end
      return hit;
   endfunction

   assign protected_hit = in_region(protect_cfg, cmd.addr);
   assign is_write_cmd = (cmd.code == CMD_WRSR) || (cmd.code == CMD_PROGRAM)
                         || (cmd.code == CMD_ERASE);
   // byte-boundary check gates every command
   // a cut command is dropped whole, never half applied
   assign accept = cmd_valid && cmd_byte_aligned;

   // command acceptance and operation timing
   // counts run to the worst-case time, so busy never drops early
   always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         state_reg <= ST_STANDBY;
         resume_state_reg <= ST_STANDBY;
         count_reg <= '0;
         saved_count_reg <= '0;
         in_dp_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_STANDBY: begin
               if (accept && !in_dp_reg && write_enable_latch) begin
                  if (cmd.code == CMD_WRSR) begin
                     state_reg <= ST_WRSR;
                     count_reg <= CNT_W'(WRSR_CYCLES - 1);
                  end else if (cmd.code == CMD_PROGRAM && !protected_hit) begin
                     state_reg <= ST_PROGRAM;
                     count_reg <= CNT_W'(PROG_CYCLES - 1);
                  end else if (cmd.code == CMD_ERASE && !protected_hit) begin
                     state_reg <= ST_ERASE;
                     count_reg <= CNT_W'(ERASE_CYCLES - 1);
                  end
               end
               if (accept && !in_dp_reg && cmd.code == CMD_DEEP_DOWN) begin
                  state_reg <= ST_DP_ENTER;
                  count_reg <= CNT_W'(DP_ENTRY_CYC - 1);
               end
               // release is the only way out of deep power-down
               if (accept && in_dp_reg && cmd.code == CMD_RELEASE) begin
                  state_reg <= ST_DP_EXIT;
                  count_reg <= CNT_W'(DP_RELEASE_CYC - 1);
               end
            end
            ST_PROGRAM, ST_ERASE: begin
               if (suspend_req) begin
                  // remaining work is kept for the resume
                  // a suspend in the last cycle still parks the operation
                  resume_state_reg <= state_reg;
                  saved_count_reg <= count_reg;
                  state_reg <= ST_SUSPENDING;
                  count_reg <= CNT_W'(SUSPEND_CYC - 1);
               end else if (count_reg == '0) begin
                  state_reg <= ST_STANDBY;
               end else begin
                  count_reg <= count_reg - 1'b1;
               end
            end
            ST_WRSR, ST_SUSPENDING: begin
               if (count_reg == '0) begin
                  if (state_reg == ST_WRSR) begin
                     state_reg <= ST_STANDBY;
                  end else begin
                     state_reg <= ST_SUSPENDED;
                  end
               end else begin
                  count_reg <= count_reg - 1'b1;
               end
            end
            ST_SUSPENDED: begin
               // spacing of resume and next suspend is the host's duty
               if (resume_req) begin
                  state_reg <= resume_state_reg;
                  count_reg <= saved_count_reg;
               end
            end
            ST_DP_ENTER, ST_DP_EXIT: begin
               if (count_reg == '0) begin
                  in_dp_reg <= (state_reg == ST_DP_ENTER);
                  state_reg <= ST_STANDBY;
               end else begin
                  count_reg <= count_reg - 1'b1;
               end
            end
            default: state_reg <= ST_STANDBY;
         endcase
      end
   end

   // write enable latch, protect field and status
   always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         write_enable_latch <= 1'b0;
         protect_cfg <= protect_cfg_s'(STATUS_RESET);
         status_byte <= STATUS_RESET;
      end else begin
         if (state_reg == ST_STANDBY && accept && !in_dp_reg) begin
            if (cmd.code == CMD_SET_WRITE_ENABLE_COMMAND) begin
               write_enable_latch <= 1'b1;
            end else if (cmd.code == CMD_WRDI) begin
               write_enable_latch <= 1'b0;
            // a refused write still spends the latch
            end else if (is_write_cmd && write_enable_latch) begin
               write_enable_latch <= 1'b0;
            end
            if (cmd.code == CMD_WRSR && write_enable_latch) begin
               status_byte <= cmd.status_data;
               // pin low keeps every protect_cfg bit except protect_complement_bit
               if (write_protect_n) begin
                  protect_cfg <= cmd.cfg_data;
               end else begin
                  protect_cfg.protect_complement_bit <=
                     cmd.cfg_data.protect_complement_bit;
               end
            end
         end
      end
   end

   // array strobes, one cycle at command acceptance
   // no handshake here: the array side never stalls a strobe
   always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         array_program <= 1'b0;
         array_erase <= 1'b0;
         array_addr <= '0;
         cmd_rejected <= 1'b0;
      end else begin
         array_program <= 1'b0;
         array_erase <= 1'b0;
         cmd_rejected <= 1'b0;
         if (state_reg == ST_STANDBY && accept && !in_dp_reg
             && write_enable_latch && !protected_hit) begin
            array_program <= (cmd.code == CMD_PROGRAM);
            array_erase <= (cmd.code == CMD_ERASE);
            array_addr <= cmd.addr;
         end
         if (cmd_valid && (!cmd_byte_aligned || state_reg != ST_STANDBY
             || (in_dp_reg && cmd.code != CMD_RELEASE)
             || (is_write_cmd && !write_enable_latch)
             || (cmd.code inside {CMD_PROGRAM, CMD_ERASE}
                 && protected_hit))) begin
            cmd_rejected <= 1'b1;
         end
      end
   end

   // registered status flags
   // flags lag the state by a cycle so each output is a flop
   always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         busy <= 1'b0;
         suspended <= 1'b0;
         deep_down <= 1'b0;
      end else begin
         busy <= !(state_reg inside {ST_STANDBY, ST_SUSPENDED});
         suspended <= (state_reg == ST_SUSPENDED);
         deep_down <= in_dp_reg;
      end
   end
endmodule : flash_protect
`default_nettype wire

// *** verif/flash_protect_checker.sv ***
// assertions on the ports of the flash protection block
`timescale 1ns/10ps
`default_nettype none
module flash_protect_checker
   import flash_protect_pkg::*;
#(
   parameter int PROG_CYCLES = 20,
   parameter int ERASE_CYCLES = 30,
   parameter int WRSR_CYCLES = 25
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // command side
   input wire logic cmd_valid,
   input wire flash_protect_pkg::cmd_s cmd,
   input wire logic cmd_byte_aligned,
   input wire logic suspend_req,
   input wire logic write_protect_n,
   // results
   input wire logic busy,
   input wire logic write_enable_latch,
   input wire logic suspended,
   input wire logic deep_down,
   input wire flash_protect_pkg::protect_cfg_s protect_cfg,
   input wire logic array_program,
   input wire logic array_erase,
   input wire logic cmd_rejected
);
   // strobe to busy low is one cycle plus the count plus slack
   localparam int ELIM = ERASE_CYCLES + 4;
   // cycles since a suspend request, held at zero once suspended shows
   localparam int SUS_LIM = 1510;
   logic [10:0] sus_wait_reg;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sus_wait_reg <= 11'h000;
      end else if (suspended) begin
         sus_wait_reg <= 11'h000;
      end else if (sus_wait_reg != 11'h000 && sus_wait_reg != 11'h7ff) begin
         sus_wait_reg <= sus_wait_reg + 11'h001;
      end else if (sus_wait_reg == 11'h000 && suspend_req && busy) begin
         sus_wait_reg <= 11'h001;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_reject_no_write: assert property (
      cmd_rejected |-> !array_program && !array_erase)
      else $error("write strobe with reject");
   a_write_needs_latch: assert property (
      ($rose(array_program) || $rose(array_erase)) |->
      $past(write_enable_latch)) else $error("write without latch");
   a_latch_spent: assert property (
      (array_program || array_erase) |-> !write_enable_latch)
      else $error("latch kept after write");
   a_unaligned_refused: assert property (
      cmd_valid && !cmd_byte_aligned |=> cmd_rejected && $stable(protect_cfg))
      else $error("unaligned command taken");
   a_deep_no_write: assert property (
      deep_down |-> !array_program && !array_erase)
      else $error("write in deep power-down");
   a_pin_holds_bits: assert property (
      !write_protect_n && !$past(write_protect_n) |->
      $stable(protect_cfg[6:0])) else $error("protect bits changed");
   a_program_pulse: assert property (
      array_program |=> !array_program && busy)
      else $error("program strobe shape");
   a_erase_time: assert property (
      array_erase |-> ##[1:ELIM] !busy) else $error("erase too long");
   a_dp_entry_time: assert property (
      cmd_valid && cmd_byte_aligned && cmd.code == CMD_DEEP_DOWN && !busy &&
      !deep_down && !suspended |-> ##[1:160] deep_down)
      else $error("deep power-down entry late");
   a_dp_release_time: assert property (
      cmd_valid && cmd_byte_aligned && cmd.code == CMD_RELEASE && deep_down
      |-> ##[1:410] !deep_down) else $error("release late");
   a_suspend_time: assert property (
      sus_wait_reg <= SUS_LIM)
      else $error("suspend late");
   c_erase: cover property (array_erase);
   c_suspend: cover property ($rose(suspended));
   c_deep: cover property ($rose(deep_down));
endmodule : flash_protect_checker
`default_nettype wire

// *** verif/flash_host.sv ***
// host controller model issuing decoded commands
`timescale 1ns/10ps
`default_nettype none
module flash_host
   import flash_protect_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // command side
   output logic cmd_valid,
   output flash_protect_pkg::cmd_s cmd,
   output logic cmd_byte_aligned,
   output logic suspend_req,
   output logic resume_req
);
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
      cmd_byte_aligned = 1'b0;
      suspend_req = 1'b0;
      resume_req = 1'b0;
   end
   // select held off after power-up before any command
   task power_up_wait();
      repeat (8) @(negedge sys_clk);
   endtask : power_up_wait
   task send(input cmd_e c, input logic [18:0] a, input logic [7:0] cf,
         input logic al);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd = {c, a, cf, cf};
      cmd_byte_aligned = al;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      // released lines show garbage, not the last command
      cmd = ~cmd;
      cmd_byte_aligned = ~al;
   endtask : send
   task write_cmd(input cmd_e c, input logic [18:0] a, input logic [7:0] cf);
      send(CMD_SET_WRITE_ENABLE_COMMAND, '0, '0, 1'b1);
      send(c, a, cf, 1'b1);
   endtask : write_cmd
   task pulse(input logic sus);
      @(negedge sys_clk);
      suspend_req = sus;
      resume_req = !sus;
      @(negedge sys_clk);
      suspend_req = 1'b0;
      resume_req = 1'b0;
      repeat (20) @(negedge sys_clk);
   endtask : pulse
endmodule : flash_host
`default_nettype wire

// *** verif/flash_protect_bench.sv ***
// self-checking bench for the flash protection block
`timescale 1ns/10ps
`default_nettype none
module flash_protect_bench;
   import flash_protect_pkg::*;
   logic sys_clk, reset_n, write_protect_n, cmd_valid, cmd_byte_aligned;
   logic suspend_req, resume_req, busy, write_enable_latch, suspended;
   logic deep_down, array_program, array_erase, cmd_rejected;
   cmd_s cmd;
   protect_cfg_s protect_cfg;
   logic [7:0] status_byte;
   logic [ADDR_W-1:0] array_addr;
   int n_errors = 0;
   int compares = 0;
   logic [18:0] probe [8] = '{19'h00fff, 19'h01000, 19'h07fff, 19'h08000,
      19'h3ffff, 19'h40000, 19'h77fff, 19'h7f000};
   flash_protect #(.PROG_CYCLES(20), .ERASE_CYCLES(30), .WRSR_CYCLES(25))
      DUT (.*);
   flash_host host (.*);
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task wait_idle();
      @(negedge sys_clk);
      for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge sys_clk);
      check(busy, 0);
   endtask : wait_idle
   task set_cfg(input logic [7:0] cf);
      host.write_cmd(CMD_WRSR, '0, cf);
      wait_idle();
   endtask : set_cfg
   function automatic logic prot(input logic [7:0] c, input logic [18:0] a);
      logic [19:0] sz;
      logic r;
      if (c[4]) sz = (c[2:0] >= 3'h4) ? 20'h08000 : 20'h00800 << c[2:0];
      else sz = 20'h08000 << c[1:0];
      if (c[2:0] == 3'h0) r = 1'b0;
      else if (c[4] ? c[2:0] == 3'h7 : c[2]) r = 1'b1;
      else if (c[3]) r = {1'b0, a} < sz;
      else r = {1'b0, a} >= 20'h80000 - sz;
      return r ^ c[7];
   endfunction : prot
   task t_guards();
      check({busy, write_enable_latch, suspended, deep_down}, 0);
      check(protect_cfg, STATUS_RESET);
      check(status_byte, STATUS_RESET);
      host.send(CMD_PROGRAM, '0, '0, 1'b1);
      check({cmd_rejected, array_program}, 2'b10);
      host.send(CMD_SET_WRITE_ENABLE_COMMAND, '0, '0, 1'b0);
      check({cmd_rejected, write_enable_latch}, 2'b10);
      $display("test guards done");
   endtask : t_guards
   task t_sweep();
      logic [7:0] cf;
      logic p;
      for (int i = 0; i < 64; i++) begin
         cf = {i[5], 2'b00, i[4:0]};
         set_cfg(cf);
         check(protect_cfg, cf);
         for (int j = 0; j < 8; j++) begin
            p = prot(cf, probe[j]);
            host.write_cmd(j[0] ? CMD_ERASE : CMD_PROGRAM, probe[j], '0);
            check({array_program | array_erase, cmd_rejected},
               p ? 2'b01 : 2'b10);
            if (!p) check(array_addr, probe[j]);
            wait_idle();
         end
      end
      $display("test sweep done");
   endtask : t_sweep
   task t_pin();
      set_cfg(8'h00);
      write_protect_n = 1'b0;
      set_cfg(8'hff);
      check(protect_cfg, 8'h80);
      write_protect_n = 1'b1;
      set_cfg(8'h00);
      check(protect_cfg, 8'h00);
      $display("test pin done");
   endtask : t_pin
   task t_deep();
      host.send(CMD_DEEP_DOWN, '0, '0, 1'b1);
      for (int k = 0; k < 200 && deep_down !== 1'b1; k++) @(negedge sys_clk);
      check(deep_down, 1);
      wait_idle();
      host.send(CMD_SET_WRITE_ENABLE_COMMAND, '0, '0, 1'b1);
      check({cmd_rejected, write_enable_latch}, 2'b10);
      host.send(CMD_RELEASE, '0, '0, 1'b1);
      for (int k = 0; k < 450 && deep_down !== 1'b0; k++) @(negedge sys_clk);
      check(deep_down, 0);
      wait_idle();
      $display("test deep done");
   endtask : t_deep
   task t_suspend();
      host.write_cmd(CMD_PROGRAM, '0, '0);
      host.pulse(1'b1);
      for (int k = 0; k < 1600 && suspended !== 1'b1; k++) @(negedge sys_clk);
      check(suspended, 1);
      host.pulse(1'b0);
      wait_idle();
      check(suspended, 0);
      $display("test suspend done");
   endtask : t_suspend
   task give_verdict();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      give_verdict();
   end
   initial begin
      reset_n = 1'b0;
      write_protect_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      reset_n = 1'b1;
      host.power_up_wait();
      t_guards();
      t_sweep();
      t_pin();
      t_deep();
      t_suspend();
      give_verdict();
   end
endmodule : flash_protect_bench
bind flash_protect flash_protect_checker #(.PROG_CYCLES(PROG_CYCLES),
   .ERASE_CYCLES(ERASE_CYCLES), .WRSR_CYCLES(WRSR_CYCLES)) chk (.*);
`default_nettype wire
